// ### fpcl_host_model.sv
`timescale 1ns/1ns
// ==========================================
// Host model driving the parallel load link
module fpcl_host_model (
  // Clock
  input wire logic mclk,
  // Link pins
  input wire logic status_n_in,
  output logic config_request_n,
  output logic load_strobe,
  output logic [31:0] load_data
);
  // Idle link: request high, strobe parked low
  initial begin
    config_request_n = 1'b1;
    load_strobe = 1'b0;
    load_data = 32'h0;
  end
  // Pins only move on falling edges, away from the sampling edge
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Request pulse of 2 us, 40 cycles at 50 ns
  task automatic request();
    config_request_n = 1'b0;
    idle(40);
    config_request_n = 1'b1;
  endtask
  // Wait for status release, then the 2 us gap before any rise
  task automatic wait_ready(input int lim, output int n);
    for (n = 0; n < lim && status_n_in !== 1'b1; n++) begin
      idle(1);
    end
    if (n < lim) begin
      idle(40);
    end
  endtask
  // One word per 400 ns strobe period; bus scrambled once hold ends
  // Each pin moves at most once per falling edge, so calls chain cleanly
  task automatic send_word(input logic [31:0] w);
    load_data = w;
    idle(2);
    load_strobe = 1'b1;
    idle(2);
    load_data = ~w;
    idle(2);
    load_strobe = 1'b0;
    idle(2);
  endtask
  // Two extra falls after completion start initialization
  task automatic two_falls();
    repeat (2) begin
      load_strobe = 1'b1;
      idle(4);
      load_strobe = 1'b0;
      idle(4);
    end
  endtask
endmodule // fpcl_host_model

// ### fpcl_map.svh
`ifndef FPCL_MAP_SVH
`define FPCL_MAP_SVH
// ==========================================
// Clock and timing
`define FPCL_CLK_NS 50
`define FPCL_REQ_TO_LOW_NS 600
`define FPCL_REQ_TO_LOW_CYC (`FPCL_REQ_TO_LOW_NS / `FPCL_CLK_NS)
`define FPCL_STATUS_MIN_US 268
`define FPCL_STATUS_MIN_CYC ((`FPCL_STATUS_MIN_US * 1000 + `FPCL_CLK_NS - 1) / `FPCL_CLK_NS)
`define FPCL_STATUS_MAX_US 1506
`define FPCL_STATUS_MAX_CYC ((`FPCL_STATUS_MAX_US * 1000) / `FPCL_CLK_NS)
`define FPCL_INIT_MIN_US 175
`define FPCL_INIT_MIN_CYC ((`FPCL_INIT_MIN_US * 1000 + `FPCL_CLK_NS - 1) / `FPCL_CLK_NS)
`define FPCL_INIT_MAX_US 437
`define FPCL_INIT_MAX_CYC ((`FPCL_INIT_MAX_US * 1000) / `FPCL_CLK_NS)
`define FPCL_UCLK_GAP_NS 40
`define FPCL_UCLK_GAP_CYC ((`FPCL_UCLK_GAP_NS + `FPCL_CLK_NS - 1) / `FPCL_CLK_NS)
`define FPCL_USER_INIT_EDGES 8576
`define FPCL_INIT_FALL_EDGES 2
`define FPCL_POR_CYC 1000
// ==========================================
// Image layout
`define FPCL_IMAGE_WORDS 64
`define FPCL_OPT_INITDONE_BIT 0
`define FPCL_OPT_UCLK_BIT 1
`endif

// ### fpcl_pkg.sv
package fpcl_pkg;
  // ==========================================
  // Types
  typedef enum logic [5:0] {
    ST_POR = 6'h01,
    ST_HOLD = 6'h02,
    ST_LOAD = 6'h04,
    ST_DONE = 6'h08,
    ST_INIT = 6'h10,
    ST_USER = 6'h20
  } fpcl_state_t;
  typedef enum logic [1:0] {
    W_X8 = 2'h0,
    W_X16 = 2'h1,
    W_X32 = 2'h2
  } fpcl_width_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } fpcl_word_t;
endpackage

// ### fpcl_port.sv
`timescale 1ns/1ns
`include "fpcl_map.svh"
module fpcl_port #(
  parameter int IMAGE_WORDS = `FPCL_IMAGE_WORDS,
  parameter int POR_CYC = `FPCL_POR_CYC,
  parameter int STATUS_MIN_CYC = `FPCL_STATUS_MIN_CYC,
  parameter int STATUS_MAX_CYC = `FPCL_STATUS_MAX_CYC,
  parameter int USER_INIT_EDGES = `FPCL_USER_INIT_EDGES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host link pins
  input wire logic config_request_n,
  input wire logic load_strobe,
  input wire logic [31:0] load_data,
  input wire logic [1:0] width_sel,
  input wire logic user_init_clock,
  // Open-drain status line
  input wire logic status_n_in,
  output logic status_n_out,
  output logic status_n_oe,
  // Open-drain init-done line
  output logic init_done_out,
  output logic init_done_oe,
  // Device side
  output logic load_complete,
  output logic user_mode,
  output fpcl_pkg::fpcl_word_t cfg_word,
  output logic [31:0] user_data
);
  localparam int WCW = $clog2(IMAGE_WORDS + 1);
  localparam int INIT_CYC = `FPCL_INIT_MIN_CYC;
  localparam int GAP_CYC = `FPCL_UCLK_GAP_CYC;

  // ==========================================
  // Parameter checks
  initial begin
    if (IMAGE_WORDS < 2 || STATUS_MIN_CYC < 1 || STATUS_MIN_CYC > STATUS_MAX_CYC ||
        POR_CYC < 1 || USER_INIT_EDGES < 1 || USER_INIT_EDGES > 65535) begin
      $error("fpcl_port: unsupported parameter values");
    end
  end

  // Lane mask for the selected bus width
  function automatic logic [31:0] lane_mask(input logic [1:0] w);
    unique case (w)
      fpcl_pkg::W_X8: lane_mask = 32'h0000_00ff;
      fpcl_pkg::W_X16: lane_mask = 32'h0000_ffff;
      default: lane_mask = 32'hffff_ffff;
    endcase
  endfunction

  // ==========================================
  // Pin synchronisers
  logic req_s1, req_s2;
  logic strb_s1, strb_s2, strb_s3;
  logic uclk_s1, uclk_s2, uclk_s3;
  logic stat_s1, stat_s2;
  logic [31:0] data_s1, data_s2;
  logic [1:0] wsel_s1, wsel_s2;

  // Data shares the strobe's latency so a detected edge sees its word
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // Request flops start at the pin's idle level, so reset leaves no false fall
      {req_s1, req_s2, stat_s1, stat_s2} <= 4'hc;
      {strb_s1, strb_s2, strb_s3, uclk_s1, uclk_s2, uclk_s3} <= 6'h00;
      {data_s1, data_s2} <= 64'h0;
      {wsel_s1, wsel_s2} <= 4'h0;
    end else begin
      {req_s2, req_s1} <= {req_s1, config_request_n};
      {stat_s2, stat_s1} <= {stat_s1, status_n_in};
      {strb_s3, strb_s2, strb_s1} <= {strb_s2, strb_s1, load_strobe};
      {uclk_s3, uclk_s2, uclk_s1} <= {uclk_s2, uclk_s1, user_init_clock};
      {data_s2, data_s1} <= {data_s1, load_data};
      {wsel_s2, wsel_s1} <= {wsel_s1, width_sel};
    end
  end

  // ==========================================
  // Edge decode
  wire strobe_rise = strb_s2 & ~strb_s3;
  wire strobe_fall = ~strb_s2 & strb_s3;
  wire uclk_rise = uclk_s2 & ~uclk_s3;
  wire [31:0] masked_data = data_s2 & lane_mask(wsel_s2);

  // ==========================================
  // Sequencer
  fpcl_pkg::fpcl_state_t state, next_state;
  logic [31:0] timer;
  logic [15:0] edge_cnt;
  logic [WCW-1:0] word_cnt;
  logic opt_initdone, opt_uclk;

  wire in_por = (state == fpcl_pkg::ST_POR);
  wire in_load = (state == fpcl_pkg::ST_LOAD);
  wire req_abort = ~req_s2 & ~in_por;
  // An external low on status stalls loading, the delayed-configuration case
  wire take_word = in_load & strobe_rise & stat_s2;
  wire last_word = take_word && (word_cnt == WCW'(IMAGE_WORDS - 1));
  wire hold_done = (timer >= 32'(STATUS_MIN_CYC - 1)) & req_s2;
  wire gap_done = (timer >= 32'(GAP_CYC));
  wire init_done_osc = ~opt_uclk & (timer >= 32'(INIT_CYC - 1));
  wire init_done_ucl = opt_uclk & gap_done & uclk_rise &
                       (edge_cnt == 16'(USER_INIT_EDGES - 1));
  wire falls_done = strobe_fall && (edge_cnt == 16'(`FPCL_INIT_FALL_EDGES - 1));

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      fpcl_pkg::ST_POR: if (timer >= 32'(POR_CYC - 1)) next_state = fpcl_pkg::ST_HOLD;
      fpcl_pkg::ST_HOLD: if (hold_done) next_state = fpcl_pkg::ST_LOAD;
      fpcl_pkg::ST_LOAD: if (last_word) next_state = fpcl_pkg::ST_DONE;
      fpcl_pkg::ST_DONE: if (falls_done) next_state = fpcl_pkg::ST_INIT;
      fpcl_pkg::ST_INIT: if (init_done_osc | init_done_ucl) next_state = fpcl_pkg::ST_USER;
      fpcl_pkg::ST_USER: next_state = fpcl_pkg::ST_USER;
    endcase
    if (req_abort) next_state = fpcl_pkg::ST_HOLD;
  end

  // Abort keeps the hold timer running so status low width is never cut short
  wire restart_timer = (next_state != state) && !(req_abort && state == fpcl_pkg::ST_HOLD);
  wire edge_hit = ((state == fpcl_pkg::ST_DONE) & strobe_fall) |
                  ((state == fpcl_pkg::ST_INIT) & opt_uclk & gap_done & uclk_rise);

  // State and counters
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= fpcl_pkg::ST_POR;
      timer <= 32'h0;
      edge_cnt <= 16'h0;
    end else begin
      state <= next_state;
      timer <= restart_timer ? 32'h0 : timer + 32'h1;
      edge_cnt <= (next_state != state) ? 16'h0 : edge_cnt + {15'h0, edge_hit};
    end
  end

  // Word count and option bits from the first word
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      word_cnt <= '0;
      opt_initdone <= 1'b0;
      opt_uclk <= 1'b0;
    end else if (state == fpcl_pkg::ST_HOLD) begin
      word_cnt <= '0;
      opt_initdone <= 1'b0;
      opt_uclk <= 1'b0;
    end else if (take_word) begin
      word_cnt <= word_cnt + WCW'(1);
      if (word_cnt == '0) begin
        opt_initdone <= masked_data[`FPCL_OPT_INITDONE_BIT];
        opt_uclk <= masked_data[`FPCL_OPT_UCLK_BIT];
      end
    end
  end

  // ==========================================
  // Output decode
  wire next_status_oe = (next_state == fpcl_pkg::ST_POR) ||
                        (next_state == fpcl_pkg::ST_HOLD);
  wire next_load_complete = (next_state == fpcl_pkg::ST_DONE) ||
                            (next_state == fpcl_pkg::ST_INIT) ||
                            (next_state == fpcl_pkg::ST_USER);
  wire next_user_mode = (next_state == fpcl_pkg::ST_USER);
  wire next_init_done_oe = opt_initdone && (next_state == fpcl_pkg::ST_LOAD ||
                           next_state == fpcl_pkg::ST_DONE ||
                           next_state == fpcl_pkg::ST_INIT);
  wire [31:0] next_user_data = user_mode ? data_s2 : 32'h0;

  // Registered pins; state outputs are decoded from next_state, so they change on the same edge as the state
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      status_n_out <= 1'b0;
      status_n_oe <= 1'b1;
      init_done_out <= 1'b0;
      init_done_oe <= 1'b0;
      load_complete <= 1'b0;
      user_mode <= 1'b0;
      cfg_word <= '0;
      user_data <= 32'h0;
    end else begin
      status_n_out <= 1'b0;
      status_n_oe <= next_status_oe;
      init_done_out <= 1'b0;
      init_done_oe <= next_init_done_oe;
      load_complete <= next_load_complete;
      user_mode <= next_user_mode;
      cfg_word <= '{valid: take_word, data: take_word ? masked_data : 32'h0};
      user_data <= next_user_data;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Helpers: status low run length, time since request high, time since complete
  logic [31:0] low_run, rel_wait, cd_run;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      low_run <= 32'h0;
      rel_wait <= 32'h0;
      cd_run <= 32'h0;
    end else begin
      low_run <= status_n_oe ? low_run + 32'h1 : 32'h0;
      rel_wait <= (status_n_oe && req_s2) ? rel_wait + 32'h1 : 32'h0;
      cd_run <= load_complete ? cd_run + 32'h1 : 32'h0;
    end
  end

  sequence s_req_fell;
    $fell(req_s2) && !in_por;
  endsequence
  sequence s_abort_seen;
    ##[1:2] (!load_complete && status_n_oe);
  endsequence

  property p_user_lines;
    user_mode |-> load_complete && !status_n_oe;
  endproperty
  a_user_lines: assert property (p_user_lines) else $error("user mode lines not high");
  property p_abort;
    s_req_fell |=> state == fpcl_pkg::ST_HOLD;
  endproperty
  a_abort: assert property (p_abort) else $error("request low did not abort");
  property p_req_low;
    s_req_fell |-> s_abort_seen;
  endproperty
  a_req_low: assert property (p_req_low) else $error("lines not low in time");
  property p_status_min;
    $fell(status_n_oe) |-> low_run >= 32'(STATUS_MIN_CYC);
  endproperty
  a_status_min: assert property (p_status_min) else $error("status low too short");
  property p_status_rel;
    status_n_oe && req_s2 |-> rel_wait < 32'(STATUS_MAX_CYC);
  endproperty
  a_status_rel: assert property (p_status_rel) else $error("status release late");
  property p_por;
    in_por |=> status_n_oe && !load_complete;
  endproperty
  a_por: assert property (p_por) else $error("status not low in power-on delay");
  property p_load_low;
    in_load |-> !load_complete;
  endproperty
  a_load_low: assert property (p_load_low) else $error("complete high while loading");
  property p_width;
    cfg_word.valid && $past(wsel_s2) == fpcl_pkg::W_X8 |-> cfg_word.data[31:8] == 24'h0;
  endproperty
  a_width: assert property (p_width) else $error("unused lanes not masked");
  property p_user_data;
    !user_mode |=> user_data == 32'h0;
  endproperty
  a_user_data: assert property (p_user_data) else $error("data pins leak to user");
  property p_image;
    $rose(load_complete) |-> word_cnt == WCW'(IMAGE_WORDS);
  endproperty
  a_image: assert property (p_image) else $error("complete before full image");
  property p_ignore;
    (state == fpcl_pkg::ST_USER) && strobe_rise |=> !cfg_word.valid;
  endproperty
  a_ignore: assert property (p_ignore) else $error("strobe used after config");
  property p_init_osc;
    $rose(user_mode) && !opt_uclk |-> cd_run >= 32'(INIT_CYC);
  endproperty
  a_init_osc: assert property (p_init_osc) else $error("oscillator init too short");
  property p_uclk_gap;
    (state == fpcl_pkg::ST_INIT) && !gap_done |=> edge_cnt == 16'h0;
  endproperty
  a_uclk_gap: assert property (p_uclk_gap) else $error("user clock used too early");
  property p_uclk_init;
    $rose(user_mode) && opt_uclk |-> $past(edge_cnt) == 16'(USER_INIT_EDGES - 1);
  endproperty
  a_uclk_init: assert property (p_uclk_init) else $error("user clock init count wrong");
  property p_initdone;
    state == fpcl_pkg::ST_INIT |-> init_done_oe == opt_initdone;
  endproperty
  a_initdone: assert property (p_initdone) else $error("init-done pin wrong");
  property p_capture;
    take_word |=> cfg_word.valid && cfg_word.data == $past(masked_data);
  endproperty
  a_capture: assert property (p_capture) else $error("word not captured");
endmodule // fpcl_port

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ==========================================
  // Signals
  localparam int WORDS = 4;
  localparam int UEDGES = 4;
  logic mclk, nrst, config_request_n, load_strobe, user_init_clock;
  logic [31:0] load_data, user_data;
  logic [1:0] width_sel;
  logic status_n_out, status_n_oe, init_done_out, init_done_oe, load_complete, user_mode;
  fpcl_pkg::fpcl_word_t cfg_word;
  logic [31:0] got_q[$];
  int failures, check_count;
  logic ext_hold;
  // Pulled-up open-drain wire; ext_hold stands for another party pulling it low
  wire status_n_in = ~status_n_oe & ~ext_hold;

  // ==========================================
  // Instances
  fpcl_port #(.IMAGE_WORDS(WORDS), .POR_CYC(20), .STATUS_MIN_CYC(10),
    .STATUS_MAX_CYC(100), .USER_INIT_EDGES(UEDGES)) fpcl_port_inst (
    .mclk(mclk), .nrst(nrst), .config_request_n(config_request_n),
    .load_strobe(load_strobe), .load_data(load_data), .width_sel(width_sel),
    .user_init_clock(user_init_clock), .status_n_in(status_n_in),
    .status_n_out(status_n_out), .status_n_oe(status_n_oe),
    .init_done_out(init_done_out), .init_done_oe(init_done_oe),
    .load_complete(load_complete), .user_mode(user_mode),
    .cfg_word(cfg_word), .user_data(user_data));
  fpcl_host_model fpcl_host_model_inst (.mclk(mclk), .status_n_in(status_n_in),
    .config_request_n(config_request_n), .load_strobe(load_strobe),
    .load_data(load_data));

  // ==========================================
  // Clocks and word monitor
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Free-running init clock, 400 ns period
  always begin
    repeat (4) @(negedge mclk);
    user_init_clock = ~user_init_clock;
  end
  always @(posedge mclk) begin
    if (cfg_word.valid === 1'b1) got_q.push_back(cfg_word.data);
  end

  // ==========================================
  // Compare, wait and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Bounded wait on load_complete (sel 0) or user_mode (sel 1)
  task automatic wait_high(input bit sel, input int lim, output int n);
    for (n = 0; n < lim && (sel ? user_mode : load_complete) !== 1'b1; n++) begin
      @(negedge mclk);
    end
    if (n >= lim) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic ready(output int n);
    fpcl_host_model_inst.wait_ready(2000, n);
    if (n >= 2000) begin
      failures++;
      complete_run();
    end
  endtask

  // ==========================================
  // Scenarios
  // Fresh power-up: status held low through the reset delay
  task automatic power_up();
    int n;
    chk({31'h0, status_n_oe}, 32'h1);
    chk({31'h0, load_complete}, 32'h0);
    ready(n);
    chk({31'h0, n >= 20}, 32'h1);
  endtask
  // Reconfigure from user mode; status is watched for its release
  task automatic reconfig();
    int n;
    fork
      fpcl_host_model_inst.request();
      begin
        fpcl_host_model_inst.idle(12);
        chk({31'h0, status_n_oe}, 32'h1);
        chk({30'h0, load_complete, user_mode}, 32'h0);
      end
    join
    chk({31'h0, status_n_oe}, 32'h1);
    ready(n);
    chk({31'h0, n <= 100}, 32'h1);
  endtask
  // Load an image at one width, initialize, then exercise user mode
  task automatic load_image(input logic [1:0] w, input logic [1:0] opt);
    logic [31:0] mask, word;
    logic [31:0] exp_q[$];
    int i, n;
    mask = (w == 2'h0) ? 32'hff : (w == 2'h1) ? 32'hffff : 32'hffffffff;
    width_sel = w;
    got_q.delete();
    for (i = 0; i < WORDS; i++) begin
      chk({31'h0, load_complete}, 32'h0);
      word = 32'h5ac396f0 + i * 32'h01010101;
      if (i == 0) word[1:0] = opt;
      exp_q.push_back(word & mask);
      fpcl_host_model_inst.send_word(word);
    end
    wait_high(1'b0, 16, n);
    chk(got_q.size(), WORDS);
    for (i = 0; i < WORDS && i < got_q.size(); i++) chk(got_q[i], exp_q[i]);
    chk({31'h0, init_done_oe}, {31'h0, opt[0]});
    fpcl_host_model_inst.two_falls();
    wait_high(1'b1, 10000, n);
    n = n + 16;
    if (opt[1]) chk({31'h0, n >= UEDGES * 8 - 8}, 32'h1);
    else chk({31'h0, n >= 3500 && n <= 8740}, 32'h1);
    chk({29'h0, config_request_n, status_n_in, load_complete}, 32'h7);
    chk({31'h0, init_done_oe}, 32'h0);
    fpcl_host_model_inst.load_data = 32'hc35a0ff0 ^ {30'h0, w};
    fpcl_host_model_inst.idle(4);
    chk(user_data, 32'hc35a0ff0 ^ {30'h0, w});
    got_q.delete();
    fpcl_host_model_inst.send_word(32'h12345678);
    fpcl_host_model_inst.idle(4);
    chk(got_q.size(), 32'h0);
    chk({30'h0, user_mode, load_complete}, 32'h3);
  endtask
  // Status stretched low outside the device: release and words both wait
  task automatic held_reconfig();
    int n;
    ext_hold = 1'b1;
    fpcl_host_model_inst.request();
    fpcl_host_model_inst.idle(30);
    chk({30'h0, status_n_oe, status_n_in}, 32'h0);
    got_q.delete();
    fpcl_host_model_inst.send_word(32'ha5c3f00f);
    fpcl_host_model_inst.idle(4);
    chk(got_q.size(), 32'h0);
    ext_hold = 1'b0;
    ready(n);
    chk({31'h0, n <= 2}, 32'h1);
  endtask
  // Reset pulled in mid-run from user mode, then a fresh power-up
  task automatic mid_reset();
    nrst = 1'b0;
    repeat (4) @(negedge mclk);
    chk({28'h0, status_n_oe, load_complete, user_mode, init_done_oe}, 32'h8);
    nrst = 1'b1;
    power_up();
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    nrst = 1'b0;
    width_sel = 2'h0;
    user_init_clock = 1'b0;
    ext_hold = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    power_up();
    load_image(2'h0, 2'h0);
    for (int w = 1; w < 4; w++) begin
      reconfig();
      load_image(w[1:0], 2'h3);
    end
    mid_reset();
    load_image(2'h2, 2'h1);
    held_reconfig();
    load_image(2'h1, 2'h2);
    complete_run();
  end
  // Hang guard at 90000 cycles, well above the expected run length
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    complete_run();
  end
endmodule // tb_top
